// *** src/ccx_exec_map.svh ***
/*
  Holds the addresses, flag bit positions, reset values and cycle counts
  of the compare, clear and complement execution unit.
  Assumes it is included by its bare name from the package and the unit.
*/
`ifndef CCX_EXEC_MAP_SVH
`define CCX_EXEC_MAP_SVH
// Address of the condition-bits register in the register space.
`define CCX_FLAGS_ADDR 8'hd5
// Reset value of every register, the condition bits included.
`define CCX_REG_RST 8'h00
// Bit positions inside the condition-bits register.
`define CCX_FLAG_C 7
`define CCX_FLAG_Z 6
`define CCX_FLAG_S 5
`define CCX_FLAG_V 4
`define CCX_FLAG_D 3
`define CCX_FLAG_H 2
// Execution times in core clock cycles.
`define CCX_CYC_SHORT 5'h04
`define CCX_CYC_LONG 5'h06
`define CCX_CYC_TAKEN 5'h12
`define CCX_CYC_NOT_TAKEN 5'h10
`endif

// *** src/ccx_exec_pkg.sv ***
/*
  Types of the compare, clear and complement execution unit.
  Assumes the map header is on the include path.
*/
`default_nettype none
`include "ccx_exec_map.svh"
package ccx_exec_pkg;
  // Opcodes served by this unit.
  typedef enum logic [7:0] {
    CCX_OP_CARRY_INVERT = 8'hef,
    CCX_OP_ZERO_FILL_R = 8'hb0,
    CCX_OP_ZERO_FILL_IR = 8'hb1,
    CCX_OP_INVERT_R = 8'h60,
    CCX_OP_INVERT_IR = 8'h61,
    CCX_OP_TEST_RR_W = 8'ha2,
    CCX_OP_TEST_RI_W = 8'ha3,
    CCX_OP_TEST_RR = 8'ha4,
    CCX_OP_TEST_RI = 8'ha5,
    CCX_OP_TEST_IMM = 8'ha6,
    CCX_OP_EQUAL_STEP = 8'hc2,
    CCX_OP_UNEQUAL_STEP = 8'hd2
  } ccx_opcode_e;
  // Phase of the unit.
  typedef enum logic {
    CCX_IDLE = 1'b0,
    CCX_EXEC = 1'b1
  } ccx_phase_e;
  // One decoded instruction as handed over by the fetch path.
  typedef struct packed {
    logic start;
    logic [7:0] opcode;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } ccx_instr_s;
  // Retirement report towards the program counter logic.
  typedef struct packed {
    logic done;
    logic pcLoad;
    logic illegal;
  } ccx_retire_s;
endpackage : ccx_exec_pkg
`default_nettype wire

// *** src/ccx_exec_unit.sv ***
/*
  Execution unit for carry invert, zero fill, invert operand, subtract
  test and the two compare-increment-branch steps, with its own
  256-byte register space holding the condition bits.
  Assumes the fetch path offers one instruction at a time on the same
  clock and takes the program counter update on retirement.
*/
// Added by the designer: strobed register access.
// Behaviour
// - Carry invert toggles carry, four cycles.
// - Carry invert keeps every other flag.
// - Condition bits live at address d5.
// - Zero fill writes zero, four cycles, no flags.
// - Invert operand stores bitwise inverse, four cycles.
// - Invert sets Z, S from bit7, clears V.
// - Subtract test only updates flags.
// - Test flags: borrow, zero, sign, overflow.
// - Five subtract test encodings decoded.
// - Equal step branches on zero difference.
// - Unequal step branches on nonzero difference.
// - Equal step always increments source pointer.
// - Unequal step always increments source pointer.
// - Branch steps take eighteen or sixteen cycles.
// - Branch steps change no flag unless the source pointer is the register at d5.
`timescale 1ns/100ps
`default_nettype none
`include "ccx_exec_map.svh"
module ccx_exec_unit #(
  parameter int PcWidth = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire ccx_exec_pkg::ccx_instr_s instr,
  input wire logic [PcWidth-1:0] nextPc,
  input wire logic [7:0] workBase,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  output logic ready,
  output ccx_exec_pkg::ccx_retire_s retire,
  output logic [PcWidth-1:0] pcOut
);
  // The offset is a byte, so a narrower counter could not hold a target.
  if (PcWidth < 8)
  begin : g_bad_width
    $error("PcWidth must be at least 8");
  end

  // All state of the unit.
  typedef struct packed {
    logic [255:0][7:0] regs; // Register space.
    ccx_exec_pkg::ccx_phase_e phase; // Idle or executing.
    logic [4:0] count; // Cycles left in the instruction.
    logic wrEn; // A data write is pending.
    logic [7:0] wrAddr; // Its address.
    logic [7:0] wrData; // Its value.
    logic flWr; // A flag update is pending.
    logic [7:0] flVal; // New condition bits.
    logic ptrEn; // A pointer increment is pending.
    logic [7:0] ptrAddr; // Pointer register address.
    logic taken; // The branch will be taken.
    logic [PcWidth-1:0] target; // Branch target.
    logic [7:0] rdata; // Register read data.
    logic done; // Retirement pulse.
    logic pcLoad; // Program counter takes pcOut.
    logic illegal; // Opcode not served here.
    logic [PcWidth-1:0] pcOut; // Target reported on retirement.
  } ccx_state_s;

  ccx_state_s st; // Registered state.
  ccx_state_s next_st; // Next state.
  logic [7:0] flagsNow; // Current condition bits.
  logic accept; // An instruction is taken this cycle.
  logic commit; // Last cycle of an instruction.

  // Working register numbers select a register within the base bank.
  function automatic logic [7:0] workAddr(input logic [7:0] base, input logic [3:0] num);
    workAddr = {base[7:4], num};
  endfunction : workAddr

  // Flags after a subtraction of s from d; D and H are kept.
  function automatic logic [7:0] subFlags(input logic [7:0] fl, input logic [7:0] d,
                                          input logic [7:0] s);
    logic [8:0] diff;
    diff = {1'b0, d} - {1'b0, s};
    subFlags = fl;
    subFlags[`CCX_FLAG_C] = diff[8];
    subFlags[`CCX_FLAG_Z] = (diff[7:0] == 8'h00);
    subFlags[`CCX_FLAG_S] = diff[7];
    subFlags[`CCX_FLAG_V] = (d[7] != s[7]) && (diff[7] != d[7]);
  endfunction : subFlags

  assign flagsNow = st.regs[`CCX_FLAGS_ADDR];
  assign ready = (st.phase == ccx_exec_pkg::CCX_IDLE);
  assign accept = ce && ready && instr.start;
  assign commit = (st.phase == ccx_exec_pkg::CCX_EXEC) && (st.count == 5'h01);
  assign regRdata = st.rdata;
  assign retire = '{done: st.done, pcLoad: st.pcLoad, illegal: st.illegal};
  assign pcOut = st.pcOut;

  // Next-state logic: register port, decode on accept, commit at the end.
  // Operands other than the step pointer are sampled when the instruction is taken,
  // so a software write during execution can change only the pointer increment, read at commit.
  always_comb
  begin
    logic [7:0] dA;
    logic [7:0] sA;
    logic [7:0] dV;
    logic [7:0] sV;
    logic [7:0] res;
    logic [PcWidth-1:0] offs;
    logic same;
    dA = 8'h00;
    sA = 8'h00;
    dV = 8'h00;
    sV = 8'h00;
    res = 8'h00;
    same = 1'b0;
    offs = {{(PcWidth-8){instr.byte3[7]}}, instr.byte3};
    next_st = st;
    next_st.done = 1'b0;
    next_st.pcLoad = 1'b0;
    next_st.illegal = 1'b0;
    next_st.rdata = 8'h00;
    // Read data stand only in the cycle after the strobe.
    if (regRd)
    begin
      next_st.rdata = st.regs[regAddr];
    end
    // Software writes land first; a commit in the same cycle overrides.
    if (regWr)
    begin
      next_st.regs[regAddr] = regWdata;
    end
    if (accept)
    begin
      next_st.phase = ccx_exec_pkg::CCX_EXEC;
      next_st.count = `CCX_CYC_SHORT - 5'h01;
      next_st.wrEn = 1'b0;
      next_st.flWr = 1'b0;
      next_st.ptrEn = 1'b0;
      next_st.taken = 1'b0;
      next_st.flVal = flagsNow;
      next_st.target = nextPc;
      case (instr.opcode)
        ccx_exec_pkg::CCX_OP_CARRY_INVERT:
        begin
          next_st.flWr = 1'b1;
          next_st.flVal[`CCX_FLAG_C] = ~flagsNow[`CCX_FLAG_C];
        end
        ccx_exec_pkg::CCX_OP_ZERO_FILL_R, ccx_exec_pkg::CCX_OP_ZERO_FILL_IR:
        begin
          // Indirect mode takes the address from the named register.
          next_st.wrEn = 1'b1;
          next_st.wrAddr = instr.opcode[0] ? st.regs[instr.byte2] : instr.byte2;
          next_st.wrData = 8'h00;
        end
        ccx_exec_pkg::CCX_OP_INVERT_R, ccx_exec_pkg::CCX_OP_INVERT_IR:
        begin
          dA = instr.opcode[0] ? st.regs[instr.byte2] : instr.byte2;
          res = ~st.regs[dA];
          next_st.wrEn = 1'b1;
          next_st.wrAddr = dA;
          next_st.wrData = res;
          next_st.flWr = 1'b1;
          next_st.flVal[`CCX_FLAG_Z] = (res == 8'h00);
          next_st.flVal[`CCX_FLAG_S] = res[7];
          next_st.flVal[`CCX_FLAG_V] = 1'b0;
        end
        ccx_exec_pkg::CCX_OP_TEST_RR_W, ccx_exec_pkg::CCX_OP_TEST_RI_W:
        begin
          // Destination in the high nibble, source in the low one.
          dV = st.regs[workAddr(workBase, instr.byte2[7:4])];
          sA = workAddr(workBase, instr.byte2[3:0]);
          sV = instr.opcode[0] ? st.regs[st.regs[sA]] : st.regs[sA];
          next_st.count = instr.opcode[0] ? `CCX_CYC_LONG - 5'h01 : `CCX_CYC_SHORT - 5'h01;
          next_st.flWr = 1'b1;
          next_st.flVal = subFlags(flagsNow, dV, sV);
        end
        ccx_exec_pkg::CCX_OP_TEST_RR, ccx_exec_pkg::CCX_OP_TEST_RI,
        ccx_exec_pkg::CCX_OP_TEST_IMM:
        begin
          // Three-byte forms: source first except for the immediate form.
          if (instr.opcode == ccx_exec_pkg::CCX_OP_TEST_IMM)
          begin
            dV = st.regs[instr.byte2];
            sV = instr.byte3;
          end
          else
          begin
            dV = st.regs[instr.byte3];
            sA = instr.opcode[0] ? st.regs[instr.byte2] : instr.byte2;
            sV = st.regs[sA];
          end
          next_st.count = `CCX_CYC_LONG - 5'h01;
          next_st.flWr = 1'b1;
          next_st.flVal = subFlags(flagsNow, dV, sV);
        end
        ccx_exec_pkg::CCX_OP_EQUAL_STEP, ccx_exec_pkg::CCX_OP_UNEQUAL_STEP:
        begin
          // Source pointer in the high nibble; no flag is written.
          sA = workAddr(workBase, instr.byte2[7:4]);
          dV = st.regs[workAddr(workBase, instr.byte2[3:0])];
          same = (dV == st.regs[st.regs[sA]]);
          next_st.taken = (instr.opcode == ccx_exec_pkg::CCX_OP_EQUAL_STEP) ? same
                                                                             : !same;
          next_st.ptrEn = 1'b1;
          next_st.ptrAddr = sA;
          next_st.target = nextPc + offs;
          next_st.count = next_st.taken ? `CCX_CYC_TAKEN - 5'h01
                                        : `CCX_CYC_NOT_TAKEN - 5'h01;
        end
        default:
        begin
          // Unknown opcodes retire at once and change nothing.
          next_st.phase = ccx_exec_pkg::CCX_IDLE;
          next_st.count = 5'h00;
          next_st.illegal = 1'b1;
          next_st.done = 1'b1;
        end
      endcase
    end
    else if (st.phase == ccx_exec_pkg::CCX_EXEC)
    begin
      next_st.count = st.count - 5'h01;
      if (commit)
      begin
        next_st.phase = ccx_exec_pkg::CCX_IDLE;
        next_st.done = 1'b1;
        next_st.pcLoad = st.taken;
        next_st.pcOut = st.target;
        if (st.wrEn)
        begin
          next_st.regs[st.wrAddr] = st.wrData;
        end
        // Eight-bit add wraps by itself.
        if (st.ptrEn)
        begin
          next_st.regs[st.ptrAddr] = st.regs[st.ptrAddr] + 8'h01;
        end
        if (st.flWr)
        begin
          next_st.regs[`CCX_FLAGS_ADDR] = st.flVal;
        end
      end
    end
  end

  // State register; clock enable low freezes everything.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else if (ce)
    begin
      st <= next_st;
    end
  end

  // Named sequences for the multi-step behaviours.
  sequence s_take(logic [7:0] op);
    accept && (instr.opcode == op);
  endsequence

  sequence s_step_taken;
    accept && (instr.opcode inside {8'hc2, 8'hd2}) ##1 st.taken;
  endsequence

  sequence s_step_skip;
    accept && (instr.opcode inside {8'hc2, 8'hd2}) ##1 !st.taken;
  endsequence

  a_carry_toggle: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    s_take(8'hef) |-> ##4 (flagsNow[`CCX_FLAG_C] != $past(flagsNow[`CCX_FLAG_C], 4)))
    else $error("carry not toggled after four cycles");

  a_carry_others: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    s_take(8'hef) |-> ##4 (flagsNow[6:0] == $past(flagsNow[6:0], 4)))
    else $error("carry invert changed another flag");

  a_flags_read: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    regRd && (regAddr == `CCX_FLAGS_ADDR) && !regWr |=> (regRdata == $past(flagsNow)))
    else $error("condition bits not read at their address");

  a_fill_zero: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    s_take(8'hb0) ##1 (!regWr)[*3] |-> ##1 (st.regs[$past(instr.byte2, 4)] == 8'h00)
    && retire.done && (flagsNow == $past(flagsNow, 4)))
    else $error("zero fill result or timing wrong");

  a_invert_flags: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    commit && st.wrEn && st.flWr |=> !flagsNow[`CCX_FLAG_V] || ($past(st.wrAddr) ==
    `CCX_FLAGS_ADDR))
    else $error("invert left overflow set");

  a_test_nowrite: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    accept && (instr.opcode inside {8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6}) |=> !st.wrEn
    && !st.ptrEn && st.flWr)
    else $error("subtract test would write an operand");

  a_step_taken: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    s_step_taken |-> (!retire.done)[*8] ##10 (retire.done && retire.pcLoad))
    else $error("taken branch step not eighteen cycles");

  a_step_skip: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    s_step_skip |-> ##15 (retire.done && !retire.pcLoad))
    else $error("untaken branch step not sixteen cycles");

  a_pointer_step: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    commit && st.ptrEn && !regWr && (st.ptrAddr != `CCX_FLAGS_ADDR) |=>
    (st.regs[$past(st.ptrAddr)] == $past(st.regs[st.ptrAddr]) + 8'h01) &&
    (flagsNow == $past(flagsNow)))
    else $error("source pointer not incremented or flags changed");

  a_branch_target: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    accept && (instr.opcode inside {8'hc2, 8'hd2}) |=> (st.target == $past(nextPc) +
    {{(PcWidth-8){$past(instr.byte3[7])}}, $past(instr.byte3)}))
    else $error("branch target not next address plus offset");

  // Retirement timing of the short and long forms. Counting from the
  // accept edge makes any slip of the down counter by one cycle show up
  // here, long before the program counter logic would notice it.
  a_short_cycles: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    accept && (instr.opcode inside {8'hef, 8'hb0, 8'hb1, 8'h60, 8'h61, 8'ha2}) |=>
    (!retire.done)[*3] ##1 retire.done)
    else $error("four cycle instruction retired at the wrong time");

  // The long subtract test forms need two extra cycles for the operand fetch.
  a_long_cycles: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    accept && (instr.opcode inside {8'ha3, 8'ha4, 8'ha5, 8'ha6}) |=>
    (!retire.done)[*5] ##1 retire.done)
    else $error("six cycle instruction retired at the wrong time");

  // An opcode outside this unit must hand control back at once, so the
  // fetch path can route it elsewhere without losing a cycle.
  a_illegal_retire: assert property (@(posedge clock) disable iff (!rst_b || !ce)
    accept && !(instr.opcode inside {8'hef, 8'hb0, 8'hb1, 8'h60, 8'h61, 8'ha2, 8'ha3,
    8'ha4, 8'ha5, 8'ha6, 8'hc2, 8'hd2}) |=> retire.done && retire.illegal && ready)
    else $error("unknown opcode not retired as illegal");
endmodule : ccx_exec_unit
`default_nettype wire

// *** testbench/tb_top.sv ***
/*
  Self-checking bench for the compare, clear and complement execution unit.
  Assumes the unit's package and map header are compiled ahead of this file.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // Expected retirement report of one offered instruction.
  typedef struct {
    int cyc;
    logic pcLoad;
    logic illegal;
    logic [15:0] pc;
  } ccx_exp_s;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  ccx_exec_pkg::ccx_instr_s instr = '0;
  logic [15:0] nextPc = 16'h0000;
  logic [7:0] workBase = 8'h10; // Bank 1, so working registers sit at 10..1f.
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic ready;
  ccx_exec_pkg::ccx_retire_s retire;
  logic [15:0] pcOut;
  logic [7:0] mem [256] = '{default: 8'h00}; // Mirror of the register space.
  logic [7:0] rdQ [$]; // Expected read data, oldest first.
  ccx_exp_s retQ [$]; // Expected retirements, oldest first.
  ccx_exp_s got;
  logic [7:0] ops [13] = '{8'hef, 8'hb0, 8'hb1, 8'h60, 8'h61, 8'ha2, 8'ha3, 8'ha4, 8'ha5,
    8'ha6, 8'hc2, 8'hd2, 8'h37};
  logic [7:0] a;
  logic [31:0] rnd;
  logic rdSeen = 1'b0;
  int errorCnt = 0;
  int testsRun = 0;
  int cnt = 0;

  ccx_exec_unit #(.PcWidth(16)) uut (.clock(clock), .rst_b(rst_b), .ce(ce), .instr(instr),
    .nextPc(nextPc), .workBase(workBase), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .ready(ready), .retire(retire),
    .pcOut(pcOut));

  // Free-running 250 MHz core clock.
  initial
  begin
    forever #2 clock = ~clock;
  end

  // Counts one comparison and reports it at once if it differs.
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    testsRun++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic testDone();
    $display("Checks %0d, mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : testDone

  // One-cycle software write; the mirror follows at once.
  task automatic wr(input logic [7:0] addr, input logic [7:0] d);
    @(posedge clock);
    regRd <= 1'b0;
    regWr <= 1'b1;
    regAddr <= addr;
    regWdata <= d;
    mem[addr] = d;
  endtask : wr

  // One-cycle software read; the answer is judged by the watcher.
  task automatic rd(input logic [7:0] addr);
    @(posedge clock);
    regWr <= 1'b0;
    regRd <= 1'b1;
    regAddr <= addr;
    rdQ.push_back(mem[addr]);
  endtask : rd

  // Offers one instruction, notes its expected outcome and holds it until taken.
  task automatic exec(input logic [7:0] op, input logic [23:0] r);
    logic [7:0] b2, b3, d, s, v, ad, f;
    logic [3:0] w;
    logic take, ill;
    int cyc, n;
    w = workBase[7:4];
    f = mem[8'hd5];
    take = 1'b0;
    ill = 1'b0;
    cyc = 4;
    // Pointers live in 10..17 and hold 20..3f, so no operand lands on the flags.
    case (op)
      8'hb1, 8'h61, 8'ha5: b2 = {5'b00010, r[2:0]};
      8'ha2, 8'ha3: b2 = {r[11:8], 1'b0, r[14:12]};
      8'hc2, 8'hd2: b2 = {1'b0, r[14:12], r[11:8]};
      default: b2 = {3'b001, r[7:3]};
    endcase
    b3 = (op == 8'ha4 || op == 8'ha5) ? {3'b001, r[20:16]} : r[23:16];
    case (op)
      8'hef: f[7] = ~f[7];
      8'hb0, 8'hb1: mem[op[0] ? mem[b2] : b2] = 8'h00;
      8'h60, 8'h61:
      begin
        ad = op[0] ? mem[b2] : b2;
        v = ~mem[ad];
        mem[ad] = v;
        f[6:4] = {v == 8'h00, v[7], 1'b0};
      end
      8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6:
      begin
        cyc = (op == 8'ha2) ? 4 : 6;
        d = (op < 8'ha4) ? mem[{w, b2[7:4]}] : (op == 8'ha6) ? mem[b2] : mem[b3];
        s = (op == 8'ha2) ? mem[{w, b2[3:0]}] : (op == 8'ha3) ? mem[mem[{w, b2[3:0]}]] :
          (op == 8'ha4) ? mem[b2] : (op == 8'ha5) ? mem[mem[b2]] : b3;
        v = d - s;
        f[7:4] = {s > d, v == 8'h00, v[7], (d[7] != s[7]) && (v[7] != d[7])};
      end
      8'hc2, 8'hd2:
      begin
        ad = {w, b2[7:4]};
        take = (mem[{w, b2[3:0]}] == mem[mem[ad]]) ^ op[4];
        mem[ad] = mem[ad] + 8'h01;
        cyc = take ? 18 : 16;
      end
      default:
      begin
        cyc = 1;
        ill = 1'b1;
      end
    endcase
    mem[8'hd5] = f;
    @(posedge clock);
    regWr <= 1'b0;
    regRd <= 1'b0;
    instr <= {1'b1, op, b2, b3};
    nextPc <= r[15:0];
    retQ.push_back('{cyc, take, ill, r[15:0] + {{8{b3[7]}}, b3}});
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ready !== 1'b1 && n < 40);
    instr.start <= 1'b0;
  endtask : exec

  // Waits for all retirements, then reads back the whole working area.
  task automatic readAll();
    int n;
    n = 0;
    while (retQ.size() != 0 && n < 60)
    begin
      @(posedge clock);
      n++;
    end
    for (int i = 0; i < 8'h48; i++)
      rd(i[7:0]);
    rd(8'hd5);
    rd(8'hff);
  endtask : readAll

  // Watcher: judges read data one cycle after each taken read and every retirement.
  always @(posedge clock)
  begin
    if (rdSeen)
      check("read data", {8'h00, regRdata}, {8'h00, rdQ.pop_front()});
    rdSeen = (regRd === 1'b1) && (ce === 1'b1);
    if (ce === 1'b1)
      cnt++;
    if (ce === 1'b1 && retire.done === 1'b1)
    begin
      got = retQ.pop_front();
      check("cycles", cnt[15:0], got.cyc[15:0]);
      check("branch", {15'h0000, retire.pcLoad}, {15'h0000, got.pcLoad});
      check("illegal", {15'h0000, retire.illegal}, {15'h0000, got.illegal});
      if (got.pcLoad)
        check("target", pcOut, got.pc);
    end
    if (instr.start === 1'b1 && ready === 1'b1 && ce === 1'b1)
      cnt = 0;
  end

  // Main sequence: reset, fill, random pairs of instructions, pointer wrap.
  initial
  begin
    void'($urandom(81516));
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'hd5);
    for (a = 8'h10; a < 8'h40; a++)
    begin
      rnd = $urandom;
      wr(a, (a < 8'h18) ? {3'b001, rnd[4:0]} : rnd[7:0]);
    end
    // Pairs go back to back, so the second offer is refused while the first runs.
    for (int i = 0; i < 52; i++)
    begin
      rnd = $urandom;
      wr(8'hd5, rnd[31:24]);
      exec(ops[i % 13], rnd[23:0]);
      rnd = $urandom;
      exec(ops[(i * 5 + 3) % 13], rnd[23:0]);
      if (i == 20)
      begin
        // A frozen stretch must not add to the cycle count.
        @(posedge clock);
        ce <= 1'b0;
        repeat (3) @(posedge clock);
        ce <= 1'b1;
      end
      readAll();
    end
    // Pointer at ff must roll over to 00.
    wr(8'h10, 8'hff);
    exec(8'hc2, 24'h000100);
    exec(8'hd2, 24'h000100);
    readAll();
    @(posedge clock);
    regRd <= 1'b0;
    repeat (4) @(posedge clock);
    check("pending", 16'(retQ.size()), 16'h0000);
    testDone();
  end

  // Watchdog: the run needs well under 20000 cycles.
  initial
  begin
    repeat (40000) @(posedge clock);
    errorCnt++;
    testDone();
  end
endmodule : tb_top
`default_nettype wire
